// ---- hdl/cclr_cfg.svh ----
`ifndef CCLR_CFG_SVH
`define CCLR_CFG_SVH
// ==========================================================================
// Register offsets (command low bits)
`define CCLR_OFS_TX_LOW 7'h06
`define CCLR_OFS_TX_HIGH 7'h07
`define CCLR_OFS_PWR_GAIN 7'h08
`define CCLR_OFS_TONE_EN 7'h09
// ==========================================================================
// Command byte layout
`define CCLR_CMD_DIR_BIT 7
// ==========================================================================
// Power/gain field positions
`define CCLR_PD_BIT 7
`define CCLR_CUT_BIT 6
`define CCLR_ADG_BIT 5
`define CCLR_DAG_BIT 4
// ==========================================================================
// Tone enable field positions
`define CCLR_TONE_B_BIT 1
`define CCLR_TONE_A_BIT 0
`define CCLR_TONE_FIX_MASK 8'h0C
// ==========================================================================
// Reset values
`define CCLR_RST_PD 1'b1
`define CCLR_RST_CUT 1'b0
`define CCLR_RST_ADG 1'b0
`define CCLR_RST_DAG 1'b0
`define CCLR_RST_TONE 1'b0
`define CCLR_ZERO_BYTE 8'h00
`endif

// ---- hdl/cclr_pkg.sv ----
package cclr_pkg;
	// Per-channel control settings
	typedef struct packed {
		logic power_down;
		logic rx_cutoff;
		logic adc_boost;
		logic dac_cut;
		logic tone_b_en;
		logic tone_a_en;
	} cclr_ctrl_t;
	// Host port byte strobe with data
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} cclr_byte_t;
	// Host port transaction phase
	typedef enum logic [1:0] {
		CCLR_IDLE,
		CCLR_WDATA
	} cclr_state_t;
endpackage

// ---- hdl/cclr_ctrl_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cclr_cfg.svh"
// Control settings for all channels, read data registered
module cclr_ctrl_bank
	import cclr_pkg::*;
#(
	parameter int CHANNELS = 4
)
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Write side
	input wire logic wr_en_in,
	input wire logic [$clog2(CHANNELS)-1:0] wr_chan_in,
	input wire logic wr_is_tone_in,
	input wire logic [7:0] wr_data_in,
	// Read side
	input wire logic [$clog2(CHANNELS)-1:0] rd_chan_in,
	output cclr_ctrl_t rd_data_out,
	// All settings
	output cclr_ctrl_t [CHANNELS-1:0] all_out
);
	// Parameter check: every select value must name a stored channel
	generate
		if (CHANNELS < 2 || (CHANNELS & (CHANNELS - 1)) != 0)
		begin : g_bad_channels
			$error("CHANNELS must be a power of two, at least 2");
		end
	endgenerate
	cclr_ctrl_t [CHANNELS-1:0] mem_q;
	cclr_ctrl_t rd_q;
	// One control word per channel
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_ch
			always_ff @(posedge mclk_in)
			begin
				if (rst_in)
				begin
					mem_q[g].power_down <= `CCLR_RST_PD;
					mem_q[g].rx_cutoff <= `CCLR_RST_CUT;
					mem_q[g].adc_boost <= `CCLR_RST_ADG;
					mem_q[g].dac_cut <= `CCLR_RST_DAG;
					mem_q[g].tone_b_en <= `CCLR_RST_TONE;
					mem_q[g].tone_a_en <= `CCLR_RST_TONE;
				end
				else if (wr_en_in && wr_chan_in == g)
				begin
					if (wr_is_tone_in)
					begin
						mem_q[g].tone_b_en <= wr_data_in[`CCLR_TONE_B_BIT];
						mem_q[g].tone_a_en <= wr_data_in[`CCLR_TONE_A_BIT];
					end
					else
					begin
						mem_q[g].power_down <= wr_data_in[`CCLR_PD_BIT];
						mem_q[g].rx_cutoff <= wr_data_in[`CCLR_CUT_BIT];
						mem_q[g].adc_boost <= wr_data_in[`CCLR_ADG_BIT];
						mem_q[g].dac_cut <= wr_data_in[`CCLR_DAG_BIT];
					end
				end
			end
		end
	endgenerate
	// Registered read port
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			rd_q <= '0;
		else
			rd_q <= mem_q[rd_chan_in];
	end
	assign rd_data_out = rd_q;
	assign all_out = mem_q;
endmodule
`default_nettype wire

// ---- hdl/cclr_regs.sv ----
// Contract
// - Low monitor read gives sample bits 7..0, or whole companded code.
// - Monitor reads never disturb the transmit sample sent to the highway.
// - High monitor read in linear coding gives sample bits 15..8.
// - High monitor read in companded coding returns zero.
// - Power register b7 powers channel down; resets to one.
// - Power register b6 cuts receive path; resets to zero.
// - Power register b5 selects +6 dB A/D gain; resets zero.
// - Power register b4 selects -6 dB D/A gain; resets zero.
// - Tone register b1, b0 enable generators; both reset to zero.
// - Command b7 is direction, low bits address; monitors are read-only.
`timescale 1ns/1ps
`default_nettype none
`include "cclr_cfg.svh"
module cclr_regs
	import cclr_pkg::*;
#(
	parameter int CHANNELS = 4
)
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Host command port byte stream
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_byte_in,
	input wire logic [$clog2(CHANNELS)-1:0] chan_sel_in,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out,
	// Transmit path
	input wire logic companded_in,
	input wire logic tx_valid_in,
	input wire logic [15:0] tx_sample_in,
	input wire logic [$clog2(CHANNELS)-1:0] tx_chan_in,
	output logic tx_valid_out,
	output logic [15:0] tx_sample_out,
	// Per-channel controls
	output logic [CHANNELS-1:0] channel_power_down_out,
	output logic [CHANNELS-1:0] receive_path_cutoff_out,
	output logic [CHANNELS-1:0] adc_gain_boost_out,
	output logic [CHANNELS-1:0] dac_gain_cut_out,
	output logic [CHANNELS-1:0] tone_gen_b_enable_out,
	output logic [CHANNELS-1:0] tone_gen_a_enable_out
);
	localparam int CW = $clog2(CHANNELS);
	// ==========================================================================
	// Parameter check: the channel select must reach every channel exactly
	generate
		if (CHANNELS < 2 || (CHANNELS & (CHANNELS - 1)) != 0)
		begin : g_bad_channels
			$error("CHANNELS must be a power of two, at least 2");
		end
	endgenerate
	// ==========================================================================
	// Command decode
	cclr_state_t state_q;
	logic [6:0] addr_q;
	logic [CW-1:0] chan_q;
	logic [15:0] mon_q [CHANNELS];
	logic rd_pend_q;
	logic [6:0] rd_addr_q;
	logic [7:0] mon_byte_q;
	logic wr_en;
	logic wr_tone;
	logic rd_cmd;
	cclr_ctrl_t bank_rd;
	cclr_ctrl_t [CHANNELS-1:0] bank_all;
	// Write data byte follows a write command
	assign wr_en = cmd_valid_in && state_q == CCLR_WDATA;
	assign wr_tone = addr_q == `CCLR_OFS_TONE_EN;
	// Read command is b7 low; monitors only ever read
	assign rd_cmd = cmd_valid_in && state_q == CCLR_IDLE
		&& !cmd_byte_in[`CCLR_CMD_DIR_BIT];
	// Phase tracking of command then data byte
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			state_q <= CCLR_IDLE;
			addr_q <= 7'h00;
			chan_q <= '0;
		end
		else if (cmd_valid_in)
		begin
			case (state_q)
				CCLR_IDLE:
				begin
					addr_q <= cmd_byte_in[6:0];
					chan_q <= chan_sel_in;
					if (cmd_byte_in[`CCLR_CMD_DIR_BIT]
						&& (cmd_byte_in[6:0] == `CCLR_OFS_PWR_GAIN
						|| cmd_byte_in[6:0] == `CCLR_OFS_TONE_EN))
						state_q <= CCLR_WDATA;
				end
				CCLR_WDATA: state_q <= CCLR_IDLE;
				default: state_q <= CCLR_IDLE;
			endcase
		end
	end
	// ==========================================================================
	// Control storage
	// Read side addresses the channel given with the read command
	cclr_ctrl_bank #(
		.CHANNELS(CHANNELS)
	) u_bank (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_en_in(wr_en),
		.wr_chan_in(chan_q),
		.wr_is_tone_in(wr_tone),
		.wr_data_in(cmd_byte_in),
		.rd_chan_in(chan_sel_in),
		.rd_data_out(bank_rd),
		.all_out(bank_all)
	);
	// ==========================================================================
	// Transmit sample capture and pass-through
	// The highway copy never depends on reads, so monitoring cannot disturb it
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			tx_valid_out <= 1'b0;
			tx_sample_out <= 16'h0000;
		end
		else
		begin
			tx_valid_out <= tx_valid_in;
			tx_sample_out <= tx_sample_in;
		end
	end
	// Latest sample per channel, only a copy for monitoring
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < CHANNELS; i++)
				mon_q[i] <= 16'h0000;
		end
		else if (tx_valid_in)
			mon_q[tx_chan_in] <= tx_sample_in;
	end
	// Compand choice is taken at the command edge, so a later mode change
	// cannot alter an answer already in flight
	// Monitor byte chosen with the read command
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= 7'h00;
			mon_byte_q <= `CCLR_ZERO_BYTE;
		end
		else
		begin
			rd_pend_q <= rd_cmd;
			rd_addr_q <= cmd_byte_in[6:0];
			if (cmd_byte_in[6:0] == `CCLR_OFS_TX_LOW)
				mon_byte_q <= mon_q[chan_sel_in][7:0];
			else if (companded_in)
				mon_byte_q <= `CCLR_ZERO_BYTE;
			else
				mon_byte_q <= mon_q[chan_sel_in][15:8];
		end
	end
	// ==========================================================================
	// Read answer byte
	// Unstored bits: power low nibble reads zero, tone b3 and b2 read one
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			rd_valid_out <= 1'b0;
			rd_data_out <= `CCLR_ZERO_BYTE;
		end
		else
		begin
			rd_valid_out <= rd_pend_q;
			case (rd_addr_q)
				`CCLR_OFS_TX_LOW, `CCLR_OFS_TX_HIGH: rd_data_out <= mon_byte_q;
				`CCLR_OFS_PWR_GAIN: rd_data_out <= {bank_rd.power_down, bank_rd.rx_cutoff,
					bank_rd.adc_boost, bank_rd.dac_cut, 4'h0};
				`CCLR_OFS_TONE_EN: rd_data_out <= `CCLR_TONE_FIX_MASK
					| {6'h00, bank_rd.tone_b_en, bank_rd.tone_a_en};
				default: rd_data_out <= `CCLR_ZERO_BYTE;
			endcase
		end
	end
	// ==========================================================================
	// Control outputs, one flop stage from the bank
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_out
			always_ff @(posedge mclk_in)
			begin
				if (rst_in)
				begin
					channel_power_down_out[g] <= `CCLR_RST_PD;
					receive_path_cutoff_out[g] <= `CCLR_RST_CUT;
					adc_gain_boost_out[g] <= `CCLR_RST_ADG;
					dac_gain_cut_out[g] <= `CCLR_RST_DAG;
					tone_gen_b_enable_out[g] <= `CCLR_RST_TONE;
					tone_gen_a_enable_out[g] <= `CCLR_RST_TONE;
				end
				else
				begin
					channel_power_down_out[g] <= bank_all[g].power_down;
					receive_path_cutoff_out[g] <= bank_all[g].rx_cutoff;
					adc_gain_boost_out[g] <= bank_all[g].adc_boost;
					dac_gain_cut_out[g] <= bank_all[g].dac_cut;
					tone_gen_b_enable_out[g] <= bank_all[g].tone_b_en;
					tone_gen_a_enable_out[g] <= bank_all[g].tone_a_en;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- testbench/cclr_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module cclr_regs_monitor
	import cclr_pkg::*;
#(
	parameter int CHANNELS = 4
)
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Host port
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_byte_in,
	input wire logic [$clog2(CHANNELS)-1:0] chan_sel_in,
	input wire logic rd_valid_out,
	input wire logic [7:0] rd_data_out,
	// Transmit path
	input wire logic companded_in,
	input wire logic tx_valid_in,
	input wire logic [15:0] tx_sample_in,
	input wire logic tx_valid_out,
	input wire logic [15:0] tx_sample_out,
	// Controls
	input wire logic [CHANNELS-1:0] channel_power_down_out,
	input wire logic [CHANNELS-1:0] receive_path_cutoff_out,
	input wire logic [CHANNELS-1:0] adc_gain_boost_out,
	input wire logic [CHANNELS-1:0] dac_gain_cut_out,
	input wire logic [CHANNELS-1:0] tone_gen_b_enable_out,
	input wire logic [CHANNELS-1:0] tone_gen_a_enable_out
);
	// ==========================================
	// Byte phase tracking
	logic ph_q;
	logic tn_q;
	logic [$clog2(CHANNELS)-1:0] ch_q;
	logic cmd;
	logic rdc;
	logic wd;
	assign cmd = cmd_valid_in && !ph_q;
	assign rdc = cmd && !cmd_byte_in[7];
	assign wd = cmd_valid_in && ph_q;
	// Data phase follows a write command to 08 or 09
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			ph_q <= 1'b0;
		else if (cmd_valid_in)
			ph_q <= !ph_q && cmd_byte_in[7] && cmd_byte_in[6:1] == 6'h04;
	end
	// Target of the pending write
	always_ff @(posedge mclk_in)
	begin
		if (cmd)
		begin
			tn_q <= cmd_byte_in[0];
			ch_q <= chan_sel_in;
		end
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	AST_TX_PASS: assert property (tx_valid_in
		|=> tx_valid_out && tx_sample_out == $past(tx_sample_in))
		else $error("Transmit copy wrong");
	AST_TX_IDLE: assert property (!tx_valid_in |=> !tx_valid_out)
		else $error("Spurious transmit");
	AST_RD_LAT: assert property (rdc |-> ##2 rd_valid_out)
		else $error("Read answer missing");
	AST_RD_ONLY: assert property (rd_valid_out |-> $past(rdc, 2))
		else $error("Unrequested answer");
	AST_HI_COMP: assert property (rdc && companded_in && cmd_byte_in[6:0] == 7'h07
		|-> ##2 rd_data_out == 8'h00)
		else $error("Companded high byte not zero");
	AST_PWR_WR: assert property (wd && !tn_q |-> ##2
		{channel_power_down_out[$past(ch_q, 2)], receive_path_cutoff_out[$past(ch_q, 2)],
		adc_gain_boost_out[$past(ch_q, 2)], dac_gain_cut_out[$past(ch_q, 2)]}
		== $past(cmd_byte_in[7:4], 2))
		else $error("Power write not applied");
	AST_TONE_WR: assert property (wd && tn_q |-> ##2
		{tone_gen_b_enable_out[$past(ch_q, 2)], tone_gen_a_enable_out[$past(ch_q, 2)]}
		== $past(cmd_byte_in[1:0], 2))
		else $error("Tone write not applied");
	AST_RST_VAL: assert property ($fell(rst_in) |-> !rd_valid_out &&
		&channel_power_down_out && !(|{receive_path_cutoff_out, adc_gain_boost_out,
		dac_gain_cut_out, tone_gen_b_enable_out, tone_gen_a_enable_out}))
		else $error("Reset values wrong");
	cover property (rdc && companded_in);
	cover property (wd && !tn_q);
	cover property (wd && tn_q);
endmodule
bind cclr_regs cclr_regs_monitor #(.CHANNELS(CHANNELS)) mon_u (.*);
`default_nettype wire

// ---- testbench/cclr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cclr_host_model
(
	// Clock
	input wire logic mclk_in,
	// Byte stream
	output logic cmd_valid_out,
	output logic [7:0] cmd_byte_out,
	output logic [1:0] chan_sel_out
);
	// Idle at start
	initial
	begin
		cmd_valid_out = 1'b0;
		cmd_byte_out = 8'h00;
		chan_sel_out = 2'h0;
	end
	// One byte, strobe left high for a following byte
	task automatic send(input logic [7:0] b, input logic [1:0] c);
		@(negedge mclk_in);
		cmd_valid_out = 1'b1;
		cmd_byte_out = b;
		chan_sel_out = c;
	endtask
	// Release, bus shows inverse of last byte
	task automatic idle();
		@(negedge mclk_in);
		cmd_valid_out = 1'b0;
		cmd_byte_out = ~cmd_byte_out;
	endtask
	// Power write, low nibble zero
	task automatic wr_pwr(input logic [3:0] v, input logic [1:0] c);
		send(8'h88, c);
		send({v, 4'h0}, c);
		idle();
	endtask
	// Tone write, b3 and b2 set
	task automatic wr_tone(input logic [1:0] v, input logic [1:0] c);
		send(8'h89, c);
		send({6'h03, v}, c);
		idle();
	endtask
endmodule
`default_nettype wire

// ---- testbench/cclr_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cclr_regs_tb;
	logic mclk_in;
	logic rst_in;
	logic cmd_valid_in;
	logic [7:0] cmd_byte_in;
	logic [1:0] chan_sel_in;
	logic rd_valid_out;
	logic [7:0] rd_data_out;
	logic companded_in;
	logic tx_valid_in;
	logic [15:0] tx_sample_in;
	logic [1:0] tx_chan_in;
	logic tx_valid_out;
	logic [15:0] tx_sample_out;
	logic [3:0] channel_power_down_out, receive_path_cutoff_out, adc_gain_boost_out;
	logic [3:0] dac_gain_cut_out, tone_gen_b_enable_out, tone_gen_a_enable_out;
	int miscompares;
	int checks;
	// ==========================================
	// Device and host
	cclr_regs #(.CHANNELS(4)) dut_u (.*);
	cclr_host_model host_u (.mclk_in(mclk_in), .cmd_valid_out(cmd_valid_in),
		.cmd_byte_out(cmd_byte_in), .chan_sel_out(chan_sel_in));
	// Clock
	always #2 mclk_in = ~mclk_in;
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Read command and its answer two cycles later
	task automatic rd(logic [7:0] a, logic [1:0] c, logic [7:0] e);
		host_u.send(a, c);
		host_u.idle();
		@(negedge mclk_in);
		chk("rd_valid", rd_valid_out, 1);
		chk("rd_data", rd_data_out, e);
	endtask
	// One transmit sample and its copy
	task automatic tx(logic [1:0] c, logic [15:0] s);
		@(negedge mclk_in);
		tx_valid_in = 1'b1;
		tx_chan_in = c;
		tx_sample_in = s;
		@(negedge mclk_in);
		chk("tx_valid", tx_valid_out, 1);
		chk("tx_sample", tx_sample_out, s);
		tx_valid_in = 1'b0;
		tx_sample_in = ~s;
	endtask
	task automatic t_rst();
		chk("pd", channel_power_down_out, 4'hF);
		chk("cut", receive_path_cutoff_out, 0);
		chk("adg", adc_gain_boost_out, 0);
		chk("dag", dac_gain_cut_out, 0);
		chk("tone", {tone_gen_b_enable_out, tone_gen_a_enable_out}, 0);
		rd(8'h08, 2'h3, 8'h80);
		rd(8'h09, 2'h0, 8'h0C);
	endtask
	task automatic t_ctl();
		int c;
		for (c = 0; c < 4; c++)
		begin
			host_u.wr_pwr(4'(4'hF >> c), c[1:0]);
			host_u.wr_tone(c[1:0], c[1:0]);
		end
		repeat (2) @(negedge mclk_in);
		chk("pd", channel_power_down_out, 4'h1);
		chk("cut", receive_path_cutoff_out, 4'h3);
		chk("adg", adc_gain_boost_out, 4'h7);
		chk("dag", dac_gain_cut_out, 4'hF);
		chk("tone", {tone_gen_b_enable_out, tone_gen_a_enable_out}, 8'hCA);
		for (c = 0; c < 4; c++)
		begin
			rd(8'h08, c[1:0], {4'(4'hF >> c), 4'h0});
			rd(8'h09, c[1:0], 8'h0C | 8'(c));
		end
	endtask
	task automatic t_mon();
		tx(2'h1, 16'h1234);
		tx(2'h3, 16'hABCD);
		rd(8'h06, 2'h1, 8'h34);
		rd(8'h07, 2'h1, 8'h12);
		companded_in = 1'b1;
		rd(8'h07, 2'h3, 8'h00);
		fork
			rd(8'h06, 2'h3, 8'hCD);
			tx(2'h0, 16'h0F0F);
		join
		companded_in = 1'b0;
	endtask
	task automatic t_ro();
		host_u.send(8'h86, 2'h0);
		rd(8'h08, 2'h0, 8'hF0);
		host_u.send(8'h87, 2'h0);
		rd(8'h0A, 2'h0, 8'h00);
	endtask
	// Main sequence
	initial
	begin
		mclk_in = 1'b0;
		rst_in = 1'b1;
		companded_in = 1'b0;
		tx_valid_in = 1'b0;
		tx_sample_in = 16'h0000;
		tx_chan_in = 2'h0;
		miscompares = 0;
		checks = 0;
		repeat (16) @(negedge mclk_in);
		rst_in = 1'b0;
		t_rst();
		t_ctl();
		t_mon();
		t_ro();
		close_out();
	end
	// Watchdog
	initial
	begin
		#20000;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
